// *** tsm_top.sv ***
// Notes on behaviour
// (R1) id low nibble holds revision number
// (R2) id holds implementation, device, maker fields
// (R3) maker field equals test-port maker identity
// (R4) read burst address increments per read
// (R5) read burst length counts down per read
// (R6) write burst address increments per write
// (R7) write burst length counts down per write
// (R8) host reloads read burst setup each burst
// (R9) host reloads write burst setup each burst
// (R10) bit zero marks 72-bit entry occupied
// (R11) write or learn refreshes next-free index
// (R12) all entries occupied drives full code one
// (R13) 144-bit partitions force index lsb zero
// (R14) host keeps both 144-bit occupancy bits equal
// (R15) bit matches if masked or data equal
// (R16) 72-bit hit needs all 72 bits
// (R17) 144-bit hit needs even-odd pair match
// (R18) 288-bit hit needs aligned quad match
// (R19) only global winner drives sram and result
// (R20) on miss, last members drive defaults
// (R21) 64K entries, data plus mask each
// (R22) partitions take widths independently
// (R23) two-bit code per partition, 11 disables
// (R24) last member: miss 0/1, idle 0/0
// (R25) last sram driver idles all ones, inactive
// (R26) lowest matching entry is local winner
// (R27) reserved bits read zero, ignore writes
//
// Chosen here: the address-and-strobe port.
module tsm_top #(
    parameter logic [3:0] REVISION = 4'h2,     // arbitrary value
    parameter logic [2:0] IMPL_NUM = 3'h5,     // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h5A,   // arbitrary value
    parameter logic [15:0] MAKER_ID = 16'h1234 // arbitrary value, same as test-port maker code
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [6:0] REG_ADDR_I,
    input wire logic [71:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [71:0] REG_RDATA_O,
    input wire logic CMD_VALID_I,
    input wire logic [1:0] CMD_OP_I,
    input wire logic CMD_MASK_SEL_I,
    input wire logic CMD_BURST_I,
    input wire logic [15:0] CMD_ADDR_I,
    input wire logic [71:0] CMD_DATA_I,
    input wire logic [287:0] CMD_KEY_I,
    output logic [71:0] ARR_RDATA_O,
    output logic ARR_RVALID_O,
    output logic SEARCH_BUSY_O,
    output logic FREE_BUSY_O,
    output logic [1:0] TABLE_FULL_OUT_O,
    output logic CASCADE_HIT_OUT_O,
    input wire logic CASCADE_PRIOR_HIT_I,
    input wire logic CASCADE_ANY_HIT_I,
    output logic SEARCH_HIT_FLAG_O,
    output logic SEARCH_RESULT_VALID_O,
    output logic RESULT_DRIVE_EN_O,
    output logic [23:0] SRAM_ADDR_OUT_O,
    output logic SRAM_CE_N_O,
    output logic SRAM_WE_N_O,
    output logic SRAM_ALE_N_O,
    output logic SRAM_DRIVE_EN_O
);
    // entry storage [R21]
    logic [71:0] data_mem [0:tsm_pkg::ENTRIES-1];
    logic [71:0] mask_mem [0:tsm_pkg::ENTRIES-1];

    logic [15:0] cfg_part_q;
    logic tail_q;
    logic stail_q;
    logic [71:0] gmask_q;
    logic [15:0] rb_addr_q;
    logic [8:0] rb_len_q;
    logic [15:0] wb_addr_q;
    logic [8:0] wb_len_q;
    logic [15:0] free_q;
    logic [71:0] info_w;

    // command decode
    logic is_rd;
    logic is_wr;
    logic is_learn;
    logic is_search;
    logic rd_burst;
    logic wr_burst;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [1:0] free_mode;
    logic learn_ok;

    assign is_rd = CMD_VALID_I && (CMD_OP_I == tsm_pkg::OP_READ);
    assign is_wr = CMD_VALID_I && (CMD_OP_I == tsm_pkg::OP_WRITE);
    assign is_learn = CMD_VALID_I && (CMD_OP_I == tsm_pkg::OP_LEARN);
    assign is_search = CMD_VALID_I && (CMD_OP_I == tsm_pkg::OP_SEARCH);
    assign rd_burst = is_rd && CMD_BURST_I && (rb_len_q != 9'h000);
    assign wr_burst = is_wr && CMD_BURST_I && (wb_len_q != 9'h000);
    assign rd_addr = CMD_BURST_I ? rb_addr_q : CMD_ADDR_I;
    assign wr_addr = CMD_BURST_I ? wb_addr_q : CMD_ADDR_I;
    assign free_mode = cfg_part_q[{free_q[15:tsm_pkg::PART_LSB], 1'b0} +: 2];
    // no learn into full table or 288-bit partitions
    assign learn_ok = is_learn && (TABLE_FULL_OUT_O != tsm_pkg::FULL_CODE)
        && (free_mode != tsm_pkg::MODE_288) && (free_mode != tsm_pkg::MODE_OFF);

    assign info_w = {40'h00_0000_0000,
                     MAKER_ID,  // [R3]
                     DEVICE_ID,
                     1'b0,
                     IMPL_NUM,
                     REVISION}; // [R1] [R2] [R27]

    // configuration registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_part_q <= tsm_pkg::CFG_PART_RST;
            tail_q <= 1'b0;
            stail_q <= 1'b0;
            gmask_q <= tsm_pkg::GMASK_RST;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == tsm_pkg::REG_CONFIG) begin
                cfg_part_q <= REG_WDATA_I[tsm_pkg::CFG_PART_LSB +: tsm_pkg::CFG_PART_W]; // [R22] [R23]
                tail_q <= REG_WDATA_I[tsm_pkg::CFG_TAIL_BIT];
                stail_q <= REG_WDATA_I[tsm_pkg::CFG_STAIL_BIT];
            end
            if (REG_ADDR_I == tsm_pkg::REG_GMASK) begin
                gmask_q <= REG_WDATA_I;
            end
        end
    end

    // read burst setup
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rb_addr_q <= tsm_pkg::BURST_ADDR_RST;
            rb_len_q <= tsm_pkg::BURST_LEN_RST;
        end else if (REG_WR_I && (REG_ADDR_I == tsm_pkg::REG_RBURST)) begin
            rb_addr_q <= REG_WDATA_I[tsm_pkg::BURST_ADDR_LSB +: tsm_pkg::IDX_W];
            rb_len_q <= REG_WDATA_I[tsm_pkg::BURST_LEN_LSB +: tsm_pkg::BURST_LEN_W];
        end else if (rd_burst) begin
            rb_addr_q <= rb_addr_q + 16'h0001; // [R4]
            rb_len_q <= rb_len_q - 9'h001;     // [R5]
        end
    end

    // write burst setup
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wb_addr_q <= tsm_pkg::BURST_ADDR_RST;
            wb_len_q <= tsm_pkg::BURST_LEN_RST;
        end else if (REG_WR_I && (REG_ADDR_I == tsm_pkg::REG_WBURST)) begin
            wb_addr_q <= REG_WDATA_I[tsm_pkg::BURST_ADDR_LSB +: tsm_pkg::IDX_W];
            wb_len_q <= REG_WDATA_I[tsm_pkg::BURST_LEN_LSB +: tsm_pkg::BURST_LEN_W];
        end else if (wr_burst) begin
            wb_addr_q <= wb_addr_q + 16'h0001; // [R6]
            wb_len_q <= wb_len_q - 9'h001;     // [R7]
        end
    end

    // register read port
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 72'h00_0000_0000_0000_0000;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                tsm_pkg::REG_CONFIG: REG_RDATA_O <= {47'h0, cfg_part_q, stail_q, tail_q, 7'h00};
                tsm_pkg::REG_GMASK: REG_RDATA_O <= gmask_q;
                tsm_pkg::REG_INFO: REG_RDATA_O <= info_w;
                tsm_pkg::REG_RBURST: REG_RDATA_O <= {44'h0, rb_len_q, 3'h0, rb_addr_q}; // [R27]
                tsm_pkg::REG_WBURST: REG_RDATA_O <= {44'h0, wb_len_q, 3'h0, wb_addr_q};
                tsm_pkg::REG_FREE: REG_RDATA_O <= {56'h0, free_q};
                default: REG_RDATA_O <= 72'h00_0000_0000_0000_0000;
            endcase
        end else begin
            REG_RDATA_O <= 72'h00_0000_0000_0000_0000;
        end
    end

    // array writes; burst with zero length is ignored
    always_ff @(posedge REF_CLK_I) begin
        if ((is_wr && !CMD_BURST_I) || wr_burst) begin
            if (CMD_MASK_SEL_I) begin
                mask_mem[wr_addr] <= CMD_DATA_I;
            end else begin
                data_mem[wr_addr] <= CMD_DATA_I;
            end
        end else if (learn_ok) begin
            data_mem[free_q] <= {CMD_DATA_I[71:1], 1'b1}; // [R10]
            mask_mem[free_q] <= {72{1'b1}};
        end
    end

    // array reads
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ARR_RDATA_O <= 72'h00_0000_0000_0000_0000;
            ARR_RVALID_O <= 1'b0;
        end else begin
            ARR_RVALID_O <= (is_rd && !CMD_BURST_I) || rd_burst;
            ARR_RDATA_O <= CMD_MASK_SEL_I ? mask_mem[rd_addr] : data_mem[rd_addr];
        end
    end

    // next-free scan, restarted by every write or accepted learn
    logic [16:0] free_cur_q;
    logic [15:0] free_e;
    logic [1:0] free_cur_mode;
    assign free_e = free_cur_q[15:0];
    assign free_cur_mode = cfg_part_q[{free_e[15:tsm_pkg::PART_LSB], 1'b0} +: 2];

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            FREE_BUSY_O <= 1'b0;
            free_cur_q <= 17'h00000;
            free_q <= 16'h0000;
            TABLE_FULL_OUT_O <= tsm_pkg::NOT_FULL_CODE;
        end else if (is_wr || learn_ok) begin
            FREE_BUSY_O <= 1'b1; // [R11]
            free_cur_q <= 17'h00000;
        end else if (FREE_BUSY_O) begin
            if (free_cur_q == tsm_pkg::SCAN_END) begin
                FREE_BUSY_O <= 1'b0;
                TABLE_FULL_OUT_O <= tsm_pkg::FULL_CODE; // [R12]
            end else if (!data_mem[free_e][tsm_pkg::OCC_BIT]) begin
                FREE_BUSY_O <= 1'b0;
                TABLE_FULL_OUT_O <= tsm_pkg::NOT_FULL_CODE;
                if (free_cur_mode == tsm_pkg::MODE_144) begin
                    free_q <= {free_e[15:1], 1'b0}; // [R13] [R14]
                end else begin
                    free_q <= free_e; // [R11]
                end
            end else begin
                free_cur_q <= free_cur_q + 17'h00001;
            end
        end
    end

    // search scan, one entry per cycle over the whole array
    tsm_pkg::tsm_srch_t srch_q;
    logic [16:0] cur_q;
    logic [287:0] key_q;
    logic grp_ok_q;
    logic found_q;
    logic [15:0] hit_idx_q;
    logic [15:0] e;
    logic [1:0] e_mode;
    logic [1:0] lane;
    logic [1:0] lane_last;
    logic [71:0] lane_key;
    logic bit_ok;
    logic grp_ok;

    assign e = cur_q[15:0];
    assign e_mode = cfg_part_q[{e[15:tsm_pkg::PART_LSB], 1'b0} +: 2];

    always_comb begin
        unique case (e_mode)
            tsm_pkg::MODE_144: begin
                lane = {1'b0, e[0]};
                lane_last = 2'h1;
            end
            tsm_pkg::MODE_288: begin
                lane = e[1:0];
                lane_last = 2'h3;
            end
            default: begin
                lane = 2'h0;
                lane_last = 2'h0;
            end
        endcase
    end

    always_comb begin
        unique case (lane)
            2'h0: lane_key = key_q[71:0];
            2'h1: lane_key = key_q[143:72];
            2'h2: lane_key = key_q[215:144];
            default: lane_key = key_q[287:216];
        endcase
    end

    // per-bit ternary match over one 72-bit entry
    assign bit_ok = &(~gmask_q | ~mask_mem[e] | ~(data_mem[e] ^ lane_key)); // [R15] [R16]
    assign grp_ok = bit_ok && ((lane == 2'h0) || grp_ok_q); // [R17] [R18]

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            srch_q <= tsm_pkg::SRCH_IDLE;
            cur_q <= 17'h00000;
            key_q <= '0;
            grp_ok_q <= 1'b0;
            found_q <= 1'b0;
            hit_idx_q <= 16'h0000;
        end else begin
            unique case (srch_q)
                tsm_pkg::SRCH_IDLE: begin
                    if (is_search) begin
                        srch_q <= tsm_pkg::SRCH_SCAN;
                        key_q <= CMD_KEY_I;
                        cur_q <= 17'h00000;
                        found_q <= 1'b0;
                        grp_ok_q <= 1'b0;
                    end
                end
                tsm_pkg::SRCH_SCAN: begin
                    if (cur_q == tsm_pkg::SCAN_END) begin
                        srch_q <= tsm_pkg::SRCH_ARB;
                    end else begin
                        grp_ok_q <= grp_ok;
                        cur_q <= cur_q + 17'h00001;
                        // first hit in ascending order is kept [R26]
                        if (!found_q && grp_ok && (lane == lane_last) && (e_mode != tsm_pkg::MODE_OFF)) begin
                            found_q <= 1'b1; // [R23]
                            hit_idx_q <= {e[15:2], e[1:0] & ~lane_last};
                        end
                    end
                end
                tsm_pkg::SRCH_ARB: begin
                    srch_q <= tsm_pkg::SRCH_IDLE;
                end
            endcase
        end
    end

    // cascade arbitration and result drive
    logic winner;
    logic arb_cycle;
    assign arb_cycle = (srch_q == tsm_pkg::SRCH_ARB);
    assign winner = arb_cycle && found_q && !CASCADE_PRIOR_HIT_I;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SEARCH_BUSY_O <= 1'b0;
            CASCADE_HIT_OUT_O <= 1'b0;
        end else begin
            SEARCH_BUSY_O <= (srch_q != tsm_pkg::SRCH_IDLE) || is_search;
            CASCADE_HIT_OUT_O <= (srch_q == tsm_pkg::SRCH_SCAN) && (cur_q == tsm_pkg::SCAN_END) && found_q;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SEARCH_HIT_FLAG_O <= 1'b0;
            SEARCH_RESULT_VALID_O <= 1'b0;
            RESULT_DRIVE_EN_O <= 1'b0;
        end else if (winner) begin
            SEARCH_HIT_FLAG_O <= 1'b1; // [R19]
            SEARCH_RESULT_VALID_O <= 1'b1;
            RESULT_DRIVE_EN_O <= 1'b1;
        end else if (arb_cycle && !CASCADE_ANY_HIT_I && tail_q) begin
            SEARCH_HIT_FLAG_O <= 1'b0; // [R20] [R24]
            SEARCH_RESULT_VALID_O <= 1'b1;
            RESULT_DRIVE_EN_O <= 1'b1;
        end else begin
            SEARCH_HIT_FLAG_O <= 1'b0; // [R24]
            SEARCH_RESULT_VALID_O <= 1'b0;
            RESULT_DRIVE_EN_O <= tail_q && !(arb_cycle && CASCADE_ANY_HIT_I);
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SRAM_ADDR_OUT_O <= tsm_pkg::SRAM_IDLE_ADDR;
            SRAM_CE_N_O <= 1'b1;
            SRAM_WE_N_O <= 1'b1;
            SRAM_ALE_N_O <= 1'b1;
            SRAM_DRIVE_EN_O <= 1'b0;
        end else if (winner) begin
            SRAM_ADDR_OUT_O <= {8'h00, hit_idx_q}; // [R19]
            SRAM_CE_N_O <= 1'b0;
            SRAM_WE_N_O <= 1'b1;
            SRAM_ALE_N_O <= 1'b0;
            SRAM_DRIVE_EN_O <= 1'b1;
        end else begin
            SRAM_ADDR_OUT_O <= tsm_pkg::SRAM_IDLE_ADDR; // [R20] [R25]
            SRAM_CE_N_O <= 1'b1;
            SRAM_WE_N_O <= 1'b1;
            SRAM_ALE_N_O <= 1'b1;
            SRAM_DRIVE_EN_O <= stail_q && !(arb_cycle && CASCADE_ANY_HIT_I);
        end
    end
endmodule

// *** tsm_pkg.sv ***
package tsm_pkg;
    // array geometry
    localparam int ENTRY_W = 72;
    localparam int ENTRIES = 65536;
    localparam int IDX_W = 16;
    localparam int KEY_W = 288;
    localparam int PART_LSB = 13;

    // register offsets on the register port
    localparam logic [6:0] REG_CONFIG = 7'h00;
    localparam logic [6:0] REG_GMASK = 7'h10;
    localparam logic [6:0] REG_INFO = 7'h38;
    localparam logic [6:0] REG_RBURST = 7'h39;
    localparam logic [6:0] REG_WBURST = 7'h3A;
    localparam logic [6:0] REG_FREE = 7'h60;

    // field positions
    localparam int INFO_REV_LSB = 0;
    localparam int INFO_IMPL_LSB = 4;
    localparam int INFO_DEV_LSB = 8;
    localparam int INFO_MAKER_LSB = 16;
    localparam int BURST_ADDR_LSB = 0;
    localparam int BURST_LEN_LSB = 19;
    localparam int BURST_LEN_W = 9;
    localparam int CFG_TAIL_BIT = 7;
    localparam int CFG_STAIL_BIT = 8;
    localparam int CFG_PART_LSB = 9;
    localparam int CFG_PART_W = 16;
    localparam int OCC_BIT = 0;

    // reset values
    localparam logic [15:0] BURST_ADDR_RST = 16'h0000;
    localparam logic [8:0] BURST_LEN_RST = 9'h000;
    localparam logic [15:0] CFG_PART_RST = 16'h0000;
    localparam logic [71:0] GMASK_RST = 72'hFF_FFFF_FFFF_FFFF_FFFF;

    // partition width codes
    localparam logic [1:0] MODE_72 = 2'h0;
    localparam logic [1:0] MODE_144 = 2'h1;
    localparam logic [1:0] MODE_288 = 2'h2;
    localparam logic [1:0] MODE_OFF = 2'h3;

    // array command codes
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_SEARCH = 2'h2;
    localparam logic [1:0] OP_LEARN = 2'h3;

    // output encodings
    localparam logic [1:0] FULL_CODE = 2'h1;
    localparam logic [1:0] NOT_FULL_CODE = 2'h0;
    localparam logic [23:0] SRAM_IDLE_ADDR = 24'hFFFFFF;
    localparam logic [16:0] SCAN_END = 17'h10000;

    typedef enum logic [1:0] {SRCH_IDLE, SRCH_SCAN, SRCH_ARB} tsm_srch_t;
endpackage

// *** tsm_casc_model.sv ***
module tsm_casc_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic local_hit_i,
    input wire logic other_hit_i,
    input wire logic other_first_i,
    output logic prior_hit_o,
    output logic any_hit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_q;
    // cascade lines carry no meaning while local_hit_i is low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            junk_q <= 1'b0;
        end else begin
            junk_q <= ~junk_q;
        end
    end
    assign prior_hit_o = local_hit_i ? (other_hit_i & other_first_i) : junk_q;
    assign any_hit_o = local_hit_i ? 1'b1 : (other_hit_i | junk_q);
endmodule

// *** tsm_chk.sv ***
module tsm_chk #(
    parameter logic [3:0] REVISION = 4'h2, // arbitrary value
    parameter logic [2:0] IMPL_NUM = 3'h5, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
    parameter logic [15:0] MAKER_ID = 16'h1234 // arbitrary value
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [6:0] REG_ADDR_I,
    input wire logic REG_RD_I,
    input wire logic [71:0] REG_RDATA_O,
    input wire logic CMD_VALID_I,
    input wire logic [1:0] CMD_OP_I,
    input wire logic ARR_RVALID_O,
    input wire logic FREE_BUSY_O,
    input wire logic CASCADE_HIT_OUT_O,
    input wire logic CASCADE_PRIOR_HIT_I,
    input wire logic SEARCH_HIT_FLAG_O,
    input wire logic SEARCH_RESULT_VALID_O,
    input wire logic [23:0] SRAM_ADDR_OUT_O,
    input wire logic SRAM_CE_N_O,
    input wire logic SRAM_WE_N_O,
    input wire logic SRAM_ALE_N_O,
    input wire logic SRAM_DRIVE_EN_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    logic info_rd;
    assign info_rd = REG_RD_I && REG_ADDR_I == tsm_pkg::REG_INFO;
    property p_rev;
        info_rd |=> REG_RDATA_O[3:0] == REVISION && REVISION != 4'h0;
    endproperty
    a_rev: assert property (p_rev) else $error("revision field wrong");
    property p_ids;
        info_rd |=> REG_RDATA_O[31:16] == MAKER_ID && REG_RDATA_O[15:8] == DEVICE_ID && REG_RDATA_O[6:4] == IMPL_NUM;
    endproperty
    a_ids: assert property (p_ids) else $error("identity fields wrong");
    property p_resv;
        info_rd |=> REG_RDATA_O[71:32] == 40'h0 && !REG_RDATA_O[7];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved id bits not zero");
    property p_rvalid;
        ARR_RVALID_O |-> $past(CMD_VALID_I) && $past(CMD_OP_I) == tsm_pkg::OP_READ;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("array data without read");
    property p_scan;
        $rose(FREE_BUSY_O) |-> $past(CMD_VALID_I)
            && ($past(CMD_OP_I) == tsm_pkg::OP_WRITE || $past(CMD_OP_I) == tsm_pkg::OP_LEARN);
    endproperty
    a_scan: assert property (p_scan) else $error("free scan without write");
    property p_win;
        $rose(SEARCH_HIT_FLAG_O) |-> $past(CASCADE_HIT_OUT_O) && !$past(CASCADE_PRIOR_HIT_I)
            && SEARCH_RESULT_VALID_O && !SRAM_CE_N_O && SRAM_DRIVE_EN_O;
    endproperty
    a_win: assert property (p_win) else $error("hit driven by non winner");
    property p_stand;
        SEARCH_RESULT_VALID_O |=> !SEARCH_RESULT_VALID_O;
    endproperty
    a_stand: assert property (p_stand) else $error("result valid too long");
    property p_idle;
        SRAM_DRIVE_EN_O && SRAM_CE_N_O |-> SRAM_ADDR_OUT_O == tsm_pkg::SRAM_IDLE_ADDR && SRAM_WE_N_O && SRAM_ALE_N_O;
    endproperty
    a_idle: assert property (p_idle) else $error("sram idle pattern wrong");
endmodule

bind tsm_top tsm_chk #(.REVISION(REVISION), .IMPL_NUM(IMPL_NUM), .DEVICE_ID(DEVICE_ID), .MAKER_ID(MAKER_ID)) u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .CMD_VALID_I(CMD_VALID_I), .CMD_OP_I(CMD_OP_I), .ARR_RVALID_O(ARR_RVALID_O),
    .FREE_BUSY_O(FREE_BUSY_O), .CASCADE_HIT_OUT_O(CASCADE_HIT_OUT_O), .CASCADE_PRIOR_HIT_I(CASCADE_PRIOR_HIT_I),
    .SEARCH_HIT_FLAG_O(SEARCH_HIT_FLAG_O), .SEARCH_RESULT_VALID_O(SEARCH_RESULT_VALID_O),
    .SRAM_ADDR_OUT_O(SRAM_ADDR_OUT_O), .SRAM_CE_N_O(SRAM_CE_N_O), .SRAM_WE_N_O(SRAM_WE_N_O),
    .SRAM_ALE_N_O(SRAM_ALE_N_O), .SRAM_DRIVE_EN_O(SRAM_DRIVE_EN_O));

// *** tsm_top_test.sv ***
module tsm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [2:0] IMPL = 3'h6; // arbitrary value
    localparam logic [7:0] DEV = 8'hA7; // arbitrary value
    localparam logic [15:0] MAKER = 16'h4E21; // arbitrary value
    localparam int NENT = 8192;
    localparam logic [71:0] INFO_EXP = {40'h0, MAKER, DEV, 1'b0, IMPL, REV};
    localparam logic [71:0] BURST_SET = 72'h20_2328; // length 4 from 9000
    logic clk, rst, reg_wr, reg_rd, cmd_valid, cmd_msel, cmd_burst, oth_hit, oth_first;
    logic [6:0] reg_addr;
    logic [71:0] reg_wdata, cmd_data, gmask, reg_rdata, arr_rdata;
    logic [1:0] cmd_op, full;
    logic [15:0] cmd_addr;
    logic [287:0] cmd_key;
    logic [95:0] r;
    logic arr_rvalid, s_busy, free_busy, casc_hit, prior, any, hit, valid, res_en, sram_en, ce_n, we_n, ale_n;
    logic [23:0] sram_addr;
    logic [71:0] mem_d [int];
    logic [71:0] mem_m [int];
    logic [31:0] seed;
    int err_count, n_compared, idx;

    tsm_top #(.REVISION(REV), .IMPL_NUM(IMPL), .DEVICE_ID(DEV), .MAKER_ID(MAKER)) DUT (
        .REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op),
        .CMD_MASK_SEL_I(cmd_msel), .CMD_BURST_I(cmd_burst), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
        .CMD_KEY_I(cmd_key), .ARR_RDATA_O(arr_rdata), .ARR_RVALID_O(arr_rvalid), .SEARCH_BUSY_O(s_busy),
        .FREE_BUSY_O(free_busy), .TABLE_FULL_OUT_O(full), .CASCADE_HIT_OUT_O(casc_hit),
        .CASCADE_PRIOR_HIT_I(prior), .CASCADE_ANY_HIT_I(any), .SEARCH_HIT_FLAG_O(hit),
        .SEARCH_RESULT_VALID_O(valid), .RESULT_DRIVE_EN_O(res_en), .SRAM_ADDR_OUT_O(sram_addr),
        .SRAM_CE_N_O(ce_n), .SRAM_WE_N_O(we_n), .SRAM_ALE_N_O(ale_n), .SRAM_DRIVE_EN_O(sram_en));

    tsm_casc_model u_casc (.clk_i(clk), .rst_i(rst), .local_hit_i(casc_hit), .other_hit_i(oth_hit),
        .other_first_i(oth_first), .prior_hit_o(prior), .any_hit_o(any));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // lowest entry of the searchable partition that matches on every bit
    function automatic int model_search(input logic [71:0] key);
        for (int i = 0; i < NENT; i++) begin
            if ((~gmask | ~mem_m[i] | ~(mem_d[i] ^ key)) === {72{1'b1}}) begin
                return i;
            end
        end
        return -1;
    endfunction

    task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [71:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_expect(input string name, input logic [6:0] a, input logic [71:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask

    task automatic arr_cmd(input logic [1:0] op, input logic [71:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_msel <= 1'b0;
        cmd_burst <= 1'b1;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    // strobe held high: one write per cycle keeps the fill short
    task automatic fill(input logic msel);
        logic [71:0] v;
        for (int i = 0; i < NENT; i++) begin
            v = msel ? ((i == 200) ? 72'hFF_FFFF_FFFF_FFFF_F000 : '1) : {56'h0, i[14:0], i != 100};
            if (msel) begin
                mem_m[i] = v;
            end else begin
                mem_d[i] = v;
            end
            @(posedge clk);
            cmd_valid <= 1'b1;
            cmd_op <= tsm_pkg::OP_WRITE;
            cmd_msel <= msel;
            cmd_burst <= 1'b0;
            cmd_addr <= i[15:0];
            cmd_data <= v;
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        {reg_wr, reg_rd, cmd_valid, cmd_msel, cmd_burst, oth_hit, oth_first} = '0;
        {reg_addr, reg_wdata, cmd_op, cmd_addr, cmd_data, cmd_key} = '0;
        rst = 1'b1;
        seed = 32'hB8308194;
        err_count = 0;
        n_compared = 0;
        gmask = 72'h7F_FFFF_FFFF_FFFF_FFFF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_expect("wburst_reset", tsm_pkg::REG_WBURST, 72'h0);
        reg_expect("rburst_reset", tsm_pkg::REG_RBURST, 72'h0);
        reg_expect("info", tsm_pkg::REG_INFO, INFO_EXP);
        reg_write(tsm_pkg::REG_INFO, '1);
        reg_expect("info_after_write", tsm_pkg::REG_INFO, INFO_EXP);
        reg_expect("unmapped", 7'h7F, 72'h0);
        reg_write(tsm_pkg::REG_RBURST, '1);
        reg_expect("rburst_fields", tsm_pkg::REG_RBURST, 72'h0FF8_FFFF);
        // last member on both buses, partition 0 narrow, partitions 1..7 off
        reg_write(tsm_pkg::REG_CONFIG, 72'h1FF_F980);
        reg_write(tsm_pkg::REG_GMASK, gmask);
        repeat (2) @(posedge clk);
        #1;
        chk("idle", {hit, valid, res_en, sram_en, ce_n, sram_addr}, {5'h07, 24'hFFFFFF});
        fill(1'b0);
        fill(1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        reg_write(tsm_pkg::REG_WBURST, BURST_SET);
        for (int k = 0; k < 5; k++) begin
            r = {rnd(), rnd(), rnd()};
            if (k < 4) begin
                mem_d[9000 + k] = {r[71:1], 1'b1};
            end
            arr_cmd(tsm_pkg::OP_WRITE, {r[71:1], 1'b1});
        end
        reg_expect("wburst_end", tsm_pkg::REG_WBURST, 72'h232C);
        reg_write(tsm_pkg::REG_RBURST, BURST_SET);
        for (int k = 0; k < 5; k++) begin
            arr_cmd(tsm_pkg::OP_READ, 72'h0);
            chk("rvalid", {71'h0, arr_rvalid}, {71'h0, k < 4});
            if (k < 4) begin
                chk("burst_rdata", arr_rdata, mem_d[9000 + k]);
            end
        end
        reg_expect("rburst_end", tsm_pkg::REG_RBURST, 72'h232C);
        for (int n = 0; n < 300 && free_busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        reg_expect("next_free", tsm_pkg::REG_FREE, 72'h64);
        chk("full", {69'h0, free_busy, full}, {69'h0, 1'b0, tsm_pkg::NOT_FULL_CODE});
        r = {rnd(), rnd(), rnd()};
        @(posedge clk);
        oth_hit <= 1'b1;
        cmd_key <= {r, r, r[23:0], 72'h259};
        idx = model_search(72'h259);
        arr_cmd(tsm_pkg::OP_SEARCH, 72'h0);
        for (int n = 0; n < 70000 && valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("result", {s_busy, casc_hit, hit, valid, res_en, sram_en, ce_n, we_n, ale_n, sram_addr},
            {9'h17A, 8'h0, idx[15:0]});
        print_verdict();
    end
endmodule
